/* pkg/uic_pkg.sv */
/*
 * Constants, types and carriers for the interface control register bank
 * of a ULPI transceiver.
 * Assumes a ULPI protocol engine that decodes register accesses into
 * an address, a data byte and one-cycle read and write strobes.
 */
package uic_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [5:0] UIC_ADDR_WRITE = 6'h07;
  localparam logic [5:0] UIC_ADDR_SET   = 6'h08;
  localparam logic [5:0] UIC_ADDR_CLEAR = 6'h09;
  localparam logic [7:0] UIC_CTRL_RESET = 8'h00;

  // ****************************************************************
  // field positions of interface_control
  // ****************************************************************
  localparam int UIC_BIT_PROTECT_DISABLE = 7;
  localparam int UIC_BIT_PASS_THROUGH    = 6;
  localparam int UIC_BIT_INVERT          = 5;
  localparam int UIC_BIT_RESERVED_HI     = 4;
  localparam int UIC_BIT_CLOCK_SUSPEND_N = 3;
  localparam int UIC_BIT_RESERVED_LO     = 2;
  localparam int UIC_BIT_THREE_WIRE      = 1;
  localparam int UIC_BIT_SIX_WIRE        = 0;

  // ****************************************************************
  // synchroniser reset level
  // ****************************************************************
  localparam logic [1:0] UIC_SYNC_RESET = 2'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    UIC_PROT_OFF   = 2'b00,
    UIC_PROT_WATCH = 2'b01,
    UIC_PROT_CLAMP = 2'b10
  } uic_prot_e;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } uic_regacc_s;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rd_valid;
    logic       rd_hit;
  } uic_regans_s;

endpackage : uic_pkg

/* design/uic_sync.sv */
/*
 * Two-flop synchroniser for pin levels.
 * Assumes the inputs are quasi-static levels from outside ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module uic_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk_i,  // core clock
  input  wire logic             rst_i,      // synchronous reset, high
  input  wire logic [WIDTH-1:0] async_i,    // pin levels
  output var  logic [WIDTH-1:0] sync_o      // synchronised levels
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } uic_sync_s;

  uic_sync_s st;
  uic_sync_s next_st;

  // ****************************************************************
  // two stages, the first is read only by the second
  // ****************************************************************
  always_comb begin
    next_st.first  = async_i;
    next_st.second = st.first;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.second;

endmodule : uic_sync

`default_nettype wire

/* design/uic_interface_control.sv */
/*
 * Interface control register bank of a ULPI transceiver: register
 * storage with write, set and clear accesses, the interface protect
 * circuit, fault indicator path and clock power control.
 * Assumes register accesses arrive already decoded from ULPI on
 * ref_clk_i, and that STP and the fault pin are raw pin levels.
 */
`timescale 1ns/1ps
`default_nettype none

module uic_interface_control (
  input  wire logic               ref_clk_i,         // core clock
  input  wire logic               rst_i,             // sync reset, high
  input  wire uic_pkg::uic_regacc_s reg_req_i,       // register access
  output var  uic_pkg::uic_regans_s reg_ans_o,       // read answer
  input  wire logic               stp_pin_i,         // stp pin level
  input  wire logic               stp_expected_i,    // stp legal now
  input  wire logic               fault_pin_i,       // fault pin level
  output var  logic               stp_pullup_en_o,   // weak stp pull-up
  output var  logic               data_pulldown_en_o,// weak data pulls
  output var  logic               link_released_o,   // link let go
  output var  logic               fault_report_o,    // reported fault
  output var  logic               clock_power_o,     // clock powered
  output var  logic               three_wire_mode_o, // 3-wire select
  output var  logic               six_wire_mode_o,   // 6-wire select
  output var  logic               mode_conflict_o,   // both modes set
  output var  logic               pass_through_o,    // indicator bit
  output var  logic [7:0]         interface_control_o // register value
);

  typedef struct packed {
    logic [7:0]         interface_control;
    uic_pkg::uic_prot_e prot;
    uic_pkg::uic_regans_s ans;
    logic               stp_pullup;
    logic               data_pulldown;
    logic               link_released;
    logic               fault_report;
    logic               clock_power;
    logic               three_wire;
    logic               six_wire;
    logic               mode_conflict;
    logic               pass_through;
  } uic_state_s;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0] pins_s;
  logic       stp_s;
  logic       fault_s;

  uic_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .async_i   ({stp_pin_i, fault_pin_i}),
    .sync_o    (pins_s)
  );

  assign stp_s   = pins_s[1];
  assign fault_s = pins_s[0];

  // ****************************************************************
  // state
  // ****************************************************************
  uic_state_s st;
  uic_state_s next_st;
  logic       hit;
  logic       disable_n;
  logic       serial;
  logic       unexpected;

  always_comb begin
    next_st = st;
    hit = (reg_req_i.addr >= uic_pkg::UIC_ADDR_WRITE) &&
          (reg_req_i.addr <= uic_pkg::UIC_ADDR_CLEAR);

    // read answer shows the value before any write in the same cycle
    next_st.ans.rd_valid = reg_req_i.rd;
    next_st.ans.rd_hit   = reg_req_i.rd && hit;
    if (reg_req_i.rd && hit) begin
      next_st.ans.rdata = st.interface_control;
    end else begin
      next_st.ans.rdata = 8'h00;
    end

    // write, set and clear; reserved bits store but drive nothing
    if (reg_req_i.wr) begin
      if (reg_req_i.addr == uic_pkg::UIC_ADDR_WRITE) begin
        next_st.interface_control = reg_req_i.wdata;
      end else if (reg_req_i.addr == uic_pkg::UIC_ADDR_SET) begin
        next_st.interface_control =
          st.interface_control | reg_req_i.wdata;
      end else if (reg_req_i.addr == uic_pkg::UIC_ADDR_CLEAR) begin
        next_st.interface_control =
          st.interface_control & ~reg_req_i.wdata;
      end
    end

    disable_n = !next_st.interface_control[
      uic_pkg::UIC_BIT_PROTECT_DISABLE];
    unexpected = stp_s && !stp_expected_i;

    // interface protect circuit
    case (st.prot)
      uic_pkg::UIC_PROT_OFF: begin
        if (disable_n) begin
          next_st.prot = uic_pkg::UIC_PROT_WATCH;
        end
      end
      uic_pkg::UIC_PROT_WATCH: begin
        if (!disable_n) begin
          next_st.prot = uic_pkg::UIC_PROT_OFF;
        end else if (unexpected) begin
          next_st.prot = uic_pkg::UIC_PROT_CLAMP;
        end
      end
      uic_pkg::UIC_PROT_CLAMP: begin
        if (!disable_n) begin
          next_st.prot = uic_pkg::UIC_PROT_OFF;
        end else if (!unexpected) begin
          next_st.prot = uic_pkg::UIC_PROT_WATCH;
        end
      end
      default: begin
        next_st.prot = uic_pkg::UIC_PROT_WATCH;
      end
    endcase

    next_st.stp_pullup    = (next_st.prot != uic_pkg::UIC_PROT_OFF);
    next_st.data_pulldown =
      (next_st.prot == uic_pkg::UIC_PROT_CLAMP);
    next_st.link_released = next_st.data_pulldown;

    // fault path: only the invert bit acts, no bus-valid gating
    next_st.fault_report = fault_s ^ next_st.interface_control[
      uic_pkg::UIC_BIT_INVERT];
    next_st.pass_through = next_st.interface_control[
      uic_pkg::UIC_BIT_PASS_THROUGH];

    // serial mode selects and clock power
    next_st.three_wire = next_st.interface_control[
      uic_pkg::UIC_BIT_THREE_WIRE];
    next_st.six_wire   = next_st.interface_control[
      uic_pkg::UIC_BIT_SIX_WIRE];
    next_st.mode_conflict =
      next_st.three_wire && next_st.six_wire;
    serial = next_st.three_wire || next_st.six_wire;
    next_st.clock_power = !serial || next_st.interface_control[
      uic_pkg::UIC_BIT_CLOCK_SUSPEND_N];
  end

  // ****************************************************************
  // register the state
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st.interface_control <= uic_pkg::UIC_CTRL_RESET;
      st.prot              <= uic_pkg::UIC_PROT_WATCH;
      st.ans               <= '0;
      st.stp_pullup        <= 1'b1;
      st.data_pulldown     <= 1'b0;
      st.link_released     <= 1'b0;
      st.fault_report      <= 1'b0;
      st.clock_power       <= 1'b1;
      st.three_wire        <= 1'b0;
      st.six_wire          <= 1'b0;
      st.mode_conflict     <= 1'b0;
      st.pass_through      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_ans_o           = st.ans;
  assign stp_pullup_en_o     = st.stp_pullup;
  assign data_pulldown_en_o  = st.data_pulldown;
  assign link_released_o     = st.link_released;
  assign fault_report_o      = st.fault_report;
  assign clock_power_o       = st.clock_power;
  assign three_wire_mode_o   = st.three_wire;
  assign six_wire_mode_o     = st.six_wire;
  assign mode_conflict_o     = st.mode_conflict;
  assign pass_through_o      = st.pass_through;
  assign interface_control_o = st.interface_control;

endmodule : uic_interface_control

`default_nettype wire

/* verification/uic_interface_control_properties.sv */
/* checker for the interface control bank, ports only.
   assumes a bind onto uic_interface_control, single clock. */
`timescale 1ns/1ps
`default_nettype none
module uic_interface_control_properties (
  input wire logic                 ref_clk_i,          // clock
  input wire logic                 rst_i,              // reset
  input wire uic_pkg::uic_regacc_s reg_req_i,          // access
  input wire uic_pkg::uic_regans_s reg_ans_o,          // answer
  input wire logic                 stp_pin_i,          // stp pin
  input wire logic                 stp_expected_i,     // stp legal
  input wire logic                 fault_pin_i,        // fault pin
  input wire logic                 stp_pullup_en_o,    // pull-up
  input wire logic                 data_pulldown_en_o, // pull-downs
  input wire logic                 link_released_o,    // released
  input wire logic                 fault_report_o,     // fault out
  input wire logic                 clock_power_o,      // clock on
  input wire logic                 three_wire_mode_o,  // 3-wire
  input wire logic                 six_wire_mode_o,    // 6-wire
  input wire logic                 mode_conflict_o,    // conflict
  input wire logic                 pass_through_o,     // pass bit
  input wire logic [7:0]           interface_control_o // register
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] ic;
  logic [7:0] nx;
  logic       hit;
  assign ic = interface_control_o;
  assign hit = reg_req_i.addr inside {[6'h07:6'h09]};
  // ****************
  // register value the access should leave behind
  // ****************
  always_comb begin
    nx = ic;
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        uic_pkg::UIC_ADDR_WRITE: nx = reg_req_i.wdata;
        uic_pkg::UIC_ADDR_SET:   nx = ic | reg_req_i.wdata;
        uic_pkg::UIC_ADDR_CLEAR: nx = ic & ~reg_req_i.wdata;
        default: nx = ic;
      endcase
    end
  end
  property p_upd; 1'b1 |=> ic == $past(nx); endproperty
  a_upd: assert property (p_upd)
    else $error("register update wrong");
  property p_rd_hit; reg_req_i.rd && hit |=> reg_ans_o.rd_valid &&
    reg_ans_o.rd_hit && reg_ans_o.rdata == $past(ic); endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read hit");
  property p_rd_miss; reg_req_i.rd && !hit |=> reg_ans_o.rd_valid &&
    !reg_ans_o.rd_hit && reg_ans_o.rdata == 8'h00; endproperty
  a_rd_miss: assert property (p_rd_miss) else $error("read miss");
  property p_pull; stp_pullup_en_o == !ic[7]; endproperty
  a_pull: assert property (p_pull) else $error("pull-up");
  property p_off; ic[7] |-> !data_pulldown_en_o; endproperty
  a_off: assert property (p_off) else $error("pull-down on");
  property p_clamp; (!rst_i && stp_pin_i && !stp_expected_i && !ic[7])[*4]
    |-> data_pulldown_en_o && link_released_o; endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  property p_expect; stp_expected_i |=> !data_pulldown_en_o; endproperty
  a_expect: assert property (p_expect) else $error("expected");
  property p_free; (!rst_i && !stp_pin_i)[*4] |-> !link_released_o;
  endproperty
  a_free: assert property (p_free) else $error("released");
  property p_fault; (!rst_i && $stable(fault_pin_i) && $stable(ic[5]))[*4]
    |-> fault_report_o == (fault_pin_i ^ ic[5]); endproperty
  a_fault: assert property (p_fault) else $error("fault");
  property p_clk; clock_power_o == (!(ic[1] | ic[0]) | ic[3]); endproperty
  a_clk: assert property (p_clk) else $error("clock power");
  property p_modes; {three_wire_mode_o, six_wire_mode_o, pass_through_o,
    mode_conflict_o} == {ic[1], ic[0], ic[6], ic[1] & ic[0]}; endproperty
  a_modes: assert property (p_modes) else $error("mode bits");
endmodule : uic_interface_control_properties
`default_nettype wire

/* verification/uic_link_model.sv */
/* link side of the stp wire.
   assumes the device pull-up enable is fed back from the design. */
`timescale 1ns/1ps
`default_nettype none
module uic_link_model (
  input  wire logic ref_clk_i,   // clock
  input  wire logic release_i,   // link lets go of stp
  input  wire logic pullup_en_i, // device weak pull-up
  output var  logic stp_o        // stp wire level
);
  logic toggle = 1'b0;
  always @(posedge ref_clk_i) toggle <= ~toggle;
  // a floating wire shows the pull-up or a changing level
  always_comb stp_o = !release_i ? 1'b0 : (pullup_en_i ? 1'b1 : toggle);
endmodule : uic_link_model
`default_nettype wire

/* verification/uic_interface_control_tb.sv */
/* self-checking bench for the interface control bank.
   assumes the design package is compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uic_interface_control_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  uic_pkg::uic_regacc_s req = '0;
  uic_pkg::uic_regans_s ans;
  logic stp, exp_stp = 1'b0, fault = 1'b0, rel = 1'b0;
  logic pu, pd, lr, fr, cp, m3, m6, mc, pt;
  logic [7:0] ic;
  int err_count = 0, compares = 0, cyc = 0;
  logic [7:0] mdl = 8'h00;
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  uic_interface_control i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .reg_req_i(req), .reg_ans_o(ans), .stp_pin_i(stp),
    .stp_expected_i(exp_stp), .fault_pin_i(fault), .stp_pullup_en_o(pu),
    .data_pulldown_en_o(pd), .link_released_o(lr), .fault_report_o(fr),
    .clock_power_o(cp), .three_wire_mode_o(m3), .six_wire_mode_o(m6),
    .mode_conflict_o(mc), .pass_through_o(pt), .interface_control_o(ic));
  uic_link_model i_link (.ref_clk_i(ref_clk_i), .release_i(rel),
    .pullup_en_i(pu), .stp_o(stp));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic acc(input logic [5:0] a, input logic [7:0] d, input bit w);
    logic hit;
    hit = a inside {[6'h07:6'h09]};
    @(posedge ref_clk_i);
    #1 req = '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk_i);
    #1 req.wr = 1'b0;
    req.rd = 1'b0;
    if (!w) begin
      chk("rd_hit", {6'h0, 1'b1, hit},
        {6'h0, ans.rd_valid, ans.rd_hit});
      chk("rdata", hit ? mdl : 8'h00, ans.rdata);
    end else if (a == 6'h07) mdl = d;
    else if (a == 6'h08) mdl = mdl | d;
    else if (a == 6'h09) mdl = mdl & ~d;
    chk("register", mdl, ic);
    chk("derived", {2'h0, !mdl[7], !(mdl[1] | mdl[0]) | mdl[3],
      mdl[1], mdl[0], mdl[6], mdl[1] & mdl[0]},
      {2'h0, pu, cp, m3, m6, pt, mc});
  endtask : acc
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    logic [5:0] a;
    logic [7:0] d;
    void'($urandom(2712));
    repeat (12) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    for (int k = 7; k <= 10; k++) acc(k[5:0], 8'h00, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      a = 6'($urandom % 4 + 7);
      d = 8'($urandom);
      d[6] = (a != 6'h09); // link keeps pass-through on
      d[1:0] = (a == 6'h08) ? 2'h0 : 2'($urandom % 3);
      acc(a, d, 1'b1);
      acc(6'($urandom % 4 + 7), 8'h00, 1'b0);
    end
    $display("test access done");
    acc(6'h07, 8'h40, 1'b1);
    rel = 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("clamp", 8'h03, {6'h0, pd, lr});
    exp_stp = 1'b1;
    @(posedge ref_clk_i);
    #1 chk("expected", 8'h00, {7'h0, pd});
    exp_stp = 1'b0;
    acc(6'h08, 8'h80, 1'b1);
    repeat (4) @(posedge ref_clk_i);
    #1 chk("disabled", 8'h00, {7'h0, pd});
    acc(6'h09, 8'h80, 1'b1);
    rel = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 chk("driven", 8'h00, {6'h0, pd, lr});
    $display("test protect done");
    for (int k = 0; k < 4; k++) begin
      acc(k[1] ? 6'h08 : 6'h09, 8'h20, 1'b1);
      fault = k[0];
      repeat (4) @(posedge ref_clk_i);
      #1 chk("fault", {7'h0, fault ^ k[1]}, {7'h0, fr});
    end
    $display("test fault done");
    complete_run();
  end
endmodule : uic_interface_control_tb
bind uic_interface_control uic_interface_control_properties i_props (.*);
`default_nettype wire
